/* core/ecic_checker.v */
/*
  Encoder and control input checker: synchronises the A and B differential encoder
  channels and the four control strip inputs, decodes quadrature or single
  channel counts, checks signal pairs and drives the sine-cosine splitter.
  Assumes encoder, strip and fault pins are asynchronous to clk; mode and configuration are
  static settings from the same clock domain.
*/
`timescale 1ns/10ps
`include "ecic_consts.vh"

// Functional notes
// - differential quadrature only in selections 7,8,9
// - index pulse never evaluated
// - strip inputs are frequency or control
// - quadrature pairs decode sensors 1 and 2
// - single channel counts A, companion gives direction
// - inverse pair must be complementary
// - homogenous pair must be equal
// - four singles have no cross check
// - mixed: first pair checked, two singles
// - sine-cosine selections forward input one
// - splitter latency about 200 ns
// - error shifts splitter output offset
// - sine-cosine input fault reaches splitter
module ecic_checker
(
  // clock and reset
  input  wire                     clk,
  input  wire                     sys_rst,
  // configuration
  input  wire [`ECIC_MODE_W-1:0]  op_mode,
  input  wire [`ECIC_CFG_W-1:0]   strip_cfg,
  input  wire                     mixed_inverse,
  // differential encoder pins, already received to logic levels
  input  wire                     diff1_a,
  input  wire                     diff1_b,
  input  wire                     diff1_z,
  input  wire                     diff2_a,
  input  wire                     diff2_b,
  input  wire                     diff2_z,
  // control input strip pins
  input  wire [3:0]               control_input_strip,
  // sine-cosine input one samples and its monitor
  input  wire [`ECIC_SC_W-1:0]    sincos_input_one_sin,
  input  wire [`ECIC_SC_W-1:0]    sincos_input_one_cos,
  input  wire                     sincos_fault,
  // frequency results
  output reg                      sensor1_step,
  output reg                      sensor1_dir,
  output reg                      sensor2_step,
  output reg                      sensor2_dir,
  // control commands and errors
  output reg  [3:0]               control_cmd,
  output reg                      pair_error,
  output wire                     safe_state,
  // splitter output
  output wire [`ECIC_SC_W-1:0]    sincos_splitter_output_sin,
  output wire [`ECIC_SC_W-1:0]    sincos_splitter_output_cos
);

  // --------------------------------------------------------------------------
  // input synchronisers
  // --------------------------------------------------------------------------
  reg  [3:0] diff_s1;
  reg  [3:0] diff_s2;
  reg  [3:0] strip_s1;
  reg  [3:0] strip_s2;
  reg        scf_s1;
  reg        scf_s2;
  reg  [3:0] diff_prev;
  reg  [3:0] strip_prev;
  reg  [`ECIC_MODE_W-1:0] mode_prev;
  reg  [`ECIC_CFG_W-1:0]  cfg_prev;
  reg        mixinv_prev;

  // two flops per pin; index channels are not sampled at all
  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      diff_s1  <= 4'h0;
      diff_s2  <= 4'h0;
      strip_s1 <= 4'h0;
      strip_s2 <= 4'h0;
      scf_s1   <= 1'b0;
      scf_s2   <= 1'b0;
    end
    else
    begin
      diff_s1  <= {diff2_b, diff2_a, diff1_b, diff1_a};
      diff_s2  <= diff_s1;
      strip_s1 <= control_input_strip;
      strip_s2 <= strip_s1;
      scf_s1   <= sincos_fault;
      scf_s2   <= scf_s1;
    end
  end

  // --------------------------------------------------------------------------
  // mode decoding
  // --------------------------------------------------------------------------
  function is_diff_mode;
    input [`ECIC_MODE_W-1:0] m;
    begin
      is_diff_mode = (m == `ECIC_MODE_DIFF7) || (m == `ECIC_MODE_DIFF8) ||
                     (m == `ECIC_MODE_DIFF9);
    end
  endfunction

  function is_sc_mode;
    input [`ECIC_MODE_W-1:0] m;
    begin
      is_sc_mode = (m == `ECIC_MODE_SC0) || (m == `ECIC_MODE_SC1) ||
                   (m == `ECIC_MODE_SC2) || (m == `ECIC_MODE_SC6);
    end
  endfunction

  // quadrature step: 1 when either channel changed
  function quad_step;
    input [1:0] prev;
    input [1:0] cur;
    begin
      quad_step = (prev != cur);
    end
  endfunction

  // quadrature direction: forward when A leads B by 90 degrees
  function quad_dir;
    input [1:0] prev;
    input [1:0] cur;
    begin
      quad_dir = prev[1] ^ cur[0];
    end
  endfunction

  wire diff_mode = is_diff_mode(op_mode);
  wire sc_mode   = is_sc_mode(op_mode);
  wire strip_freq = !diff_mode && !sc_mode &&
                    ((strip_cfg == `ECIC_CFG_QUAD) || (strip_cfg == `ECIC_CFG_SINGLE_CH));
  wire reconfig = (op_mode != mode_prev) || (strip_cfg != cfg_prev) ||
                  (mixed_inverse != mixinv_prev);

  // --------------------------------------------------------------------------
  // frequency decoding
  // --------------------------------------------------------------------------
  reg [1:0] next_step;
  reg [1:0] next_dir;

  // select the source and decode steps for both sensors
  always @*
  begin
    next_step = 2'b00;
    next_dir  = {sensor2_dir, sensor1_dir};
    if (diff_mode)
    begin
      next_step[0] = quad_step(diff_prev[1:0], diff_s2[1:0]);
      next_step[1] = quad_step(diff_prev[3:2], diff_s2[3:2]);
      if (next_step[0])
        next_dir[0] = quad_dir(diff_prev[1:0], diff_s2[1:0]);
      if (next_step[1])
        next_dir[1] = quad_dir(diff_prev[3:2], diff_s2[3:2]);
    end
    else if (strip_freq && (strip_cfg == `ECIC_CFG_QUAD))
    begin
      next_step[0] = quad_step(strip_prev[1:0], strip_s2[1:0]);
      next_step[1] = quad_step(strip_prev[3:2], strip_s2[3:2]);
      if (next_step[0])
        next_dir[0] = quad_dir(strip_prev[1:0], strip_s2[1:0]);
      if (next_step[1])
        next_dir[1] = quad_dir(strip_prev[3:2], strip_s2[3:2]);
    end
    else if (strip_freq)
    begin
      next_step[0] = strip_s2[0] && !strip_prev[0];
      next_step[1] = strip_s2[2] && !strip_prev[2];
      next_dir[0]  = strip_s2[1];
      next_dir[1]  = strip_s2[3];
    end
  end

  // --------------------------------------------------------------------------
  // pair checking
  // --------------------------------------------------------------------------
  reg       next_mismatch;
  reg [3:0] next_cmd;

  // compare partner inputs per configuration; source must keep pairs legal
  always @*
  begin
    next_mismatch = 1'b0;
    next_cmd      = 4'h0;
    if (!diff_mode && !sc_mode)
    begin
      case (strip_cfg)
        `ECIC_CFG_INVERSE:
        begin
          next_mismatch = (strip_s2[0] == strip_s2[1]) ||
                          (strip_s2[2] == strip_s2[3]);
          next_cmd      = {2'b00, strip_s2[2], strip_s2[0]};
        end
        `ECIC_CFG_HOMOG:
        begin
          next_mismatch = (strip_s2[0] != strip_s2[1]) ||
                          (strip_s2[2] != strip_s2[3]);
          next_cmd      = {2'b00, strip_s2[2], strip_s2[0]};
        end
        `ECIC_CFG_SINGLES:
        begin
          next_cmd = strip_s2;
        end
        `ECIC_CFG_MIXED:
        begin
          next_mismatch = mixed_inverse ? (strip_s2[0] == strip_s2[1]) :
                                          (strip_s2[0] != strip_s2[1]);
          next_cmd      = {1'b0, strip_s2[3], strip_s2[2], strip_s2[0]};
        end
        default:
        begin
          next_mismatch = 1'b0;
          next_cmd      = 4'h0;
        end
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // state registers
  // --------------------------------------------------------------------------
  // history, outputs and the sticky pair error
  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      diff_prev    <= 4'h0;
      strip_prev   <= 4'h0;
      mode_prev    <= `ECIC_MODE_SC0;
      cfg_prev     <= `ECIC_CFG_QUAD;
      mixinv_prev  <= 1'b0;
      sensor1_step <= 1'b0;
      sensor2_step <= 1'b0;
      sensor1_dir  <= 1'b0;
      sensor2_dir  <= 1'b0;
      control_cmd  <= 4'h0;
      pair_error   <= 1'b0;
    end
    else
    begin
      diff_prev    <= diff_s2;
      strip_prev   <= strip_s2;
      mode_prev    <= op_mode;
      cfg_prev     <= strip_cfg;
      mixinv_prev  <= mixed_inverse;
      sensor1_step <= next_step[0];
      sensor2_step <= next_step[1];
      sensor1_dir  <= next_dir[0];
      sensor2_dir  <= next_dir[1];
      control_cmd  <= pair_error ? 4'h0 : next_cmd;
      // mismatch in the same cycle as reconfiguration still sets
      if (next_mismatch)
        pair_error <= 1'b1;
      else if (reconfig)
        pair_error <= 1'b0;
    end
  end

  assign safe_state = pair_error || scf_s2;

  // --------------------------------------------------------------------------
  // sine-cosine splitter
  // --------------------------------------------------------------------------
  ecic_splitter u_split
  (
    .clk     (clk),
    .sys_rst (sys_rst),
    .enable  (sc_mode),
    .fault   (pair_error || scf_s2 || !sc_mode),
    .sin_in  (sincos_input_one_sin),
    .cos_in  (sincos_input_one_cos),
    .sin_out (sincos_splitter_output_sin),
    .cos_out (sincos_splitter_output_cos)
  );

endmodule // ecic_checker

/* core/ecic_consts.vh */
/*
  Constants of the encoder and control input checker: operating selection codes,
  input configuration codes, splitter latency and offset codes.
  Assumes a 20 MHz clock; included by the checker and its splitter stage.
*/
`ifndef ECIC_CONSTS_VH
`define ECIC_CONSTS_VH

// ----------------------------------------------------------------------------
// operating selection
// ----------------------------------------------------------------------------
`define ECIC_MODE_W          4
`define ECIC_MODE_SC0        4'h0
`define ECIC_MODE_SC1        4'h1
`define ECIC_MODE_SC2        4'h2
`define ECIC_MODE_SC6        4'h6
`define ECIC_MODE_DIFF7      4'h7
`define ECIC_MODE_DIFF8      4'h8
`define ECIC_MODE_DIFF9      4'h9

// ----------------------------------------------------------------------------
// control input strip configuration
// ----------------------------------------------------------------------------
`define ECIC_CFG_W           3
`define ECIC_CFG_QUAD        3'h0
`define ECIC_CFG_SINGLE_CH   3'h1
`define ECIC_CFG_INVERSE     3'h2
`define ECIC_CFG_HOMOG       3'h3
`define ECIC_CFG_SINGLES     3'h4
`define ECIC_CFG_MIXED       3'h5

// ----------------------------------------------------------------------------
// splitter timing and offset
// ----------------------------------------------------------------------------
`define ECIC_CLK_NS          50
`define ECIC_SPLIT_DELAY_NS  200
`define ECIC_SPLIT_CYC       (`ECIC_SPLIT_DELAY_NS / `ECIC_CLK_NS)
`define ECIC_SC_W            12
`define ECIC_OFS_NORMAL      12'h800
`define ECIC_OFS_FAULT       12'h200

`endif

/* core/ecic_splitter.v */
/*
  Sine-cosine splitter stage: delays the first sine-cosine input words by a
  fixed pipeline and replaces the output offset when an error is present.
  Assumes input words are already synchronous to clk.
*/
`timescale 1ns/10ps
`include "ecic_consts.vh"

module ecic_splitter
(
  // clock and reset
  input  wire                   clk,
  input  wire                   sys_rst,
  // control
  input  wire                   enable,
  input  wire                   fault,
  // sample in, centred on zero
  input  wire [`ECIC_SC_W-1:0]  sin_in,
  input  wire [`ECIC_SC_W-1:0]  cos_in,
  // sample out with offset
  output reg  [`ECIC_SC_W-1:0]  sin_out,
  output reg  [`ECIC_SC_W-1:0]  cos_out
);

  localparam DEPTH = `ECIC_SPLIT_CYC - 1;

  reg [`ECIC_SC_W-1:0] sin_pipe [0:DEPTH-1];
  reg [`ECIC_SC_W-1:0] cos_pipe [0:DEPTH-1];
  integer i;

  // offset chosen per error state
  function [`ECIC_SC_W-1:0] add_ofs;
    input [`ECIC_SC_W-1:0] s;
    input                  f;
    begin
      add_ofs = s + (f ? `ECIC_OFS_FAULT : `ECIC_OFS_NORMAL);
    end
  endfunction

  // delay line, last stage adds the offset
  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      for (i = 0; i < DEPTH; i = i + 1)
      begin
        sin_pipe[i] <= 12'h000;
        cos_pipe[i] <= 12'h000;
      end
      sin_out <= `ECIC_OFS_NORMAL;
      cos_out <= `ECIC_OFS_NORMAL;
    end
    else
    begin
      sin_pipe[0] <= enable ? sin_in : 12'h000;
      cos_pipe[0] <= enable ? cos_in : 12'h000;
      for (i = 1; i < DEPTH; i = i + 1)
      begin
        sin_pipe[i] <= sin_pipe[i-1];
        cos_pipe[i] <= cos_pipe[i-1];
      end
      sin_out <= add_ofs(sin_pipe[DEPTH-1], fault);
      cos_out <= add_ofs(cos_pipe[DEPTH-1], fault);
    end
  end

endmodule // ecic_splitter

/* sim/ecic_monitor_checker.sv */
/* ecic_monitor: concurrent checks on the ports of the input checker.
   assumes the constants header and one clock with sync reset. */
`timescale 1ns/10ps
`include "ecic_consts.vh"
module ecic_monitor
(
  // clock and reset
  input wire                    clk,
  input wire                    sys_rst,
  // settings and pins
  input wire [`ECIC_MODE_W-1:0] op_mode,
  input wire [`ECIC_CFG_W-1:0]  strip_cfg,
  input wire                    mixed_inverse,
  input wire [3:0]              control_input_strip,
  input wire [`ECIC_SC_W-1:0]   sincos_input_one_sin,
  input wire                    sincos_fault,
  // results
  input wire                    sensor1_step,
  input wire [3:0]              control_cmd,
  input wire                    pair_error,
  input wire                    safe_state,
  input wire [`ECIC_SC_W-1:0]   sincos_splitter_output_sin
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  // sine-cosine and strip selections
  wire sc = (op_mode == `ECIC_MODE_SC0) || (op_mode == `ECIC_MODE_SC1) || (op_mode == `ECIC_MODE_SC2)
            || (op_mode == `ECIC_MODE_SC6);
  wire st = !sc && ((op_mode < `ECIC_MODE_DIFF7) || (op_mode > `ECIC_MODE_DIFF9));
  wire [1:0] p1 = control_input_strip[1:0];
  wire [1:0] p2 = control_input_strip[3:2];
  // ---------------------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------------------
  property p_quad;
    (st && strip_cfg == `ECIC_CFG_QUAD && $countones(p1 ^ $past(p1)) == 1) |-> ##3 sensor1_step;
  endproperty
  a_quad: assert property (p_quad) else $error("quadrature edge gave no step");
  property p_inv;
    (st && strip_cfg == `ECIC_CFG_INVERSE && (p1[0] == p1[1] || p2[0] == p2[1]))[*4] |-> pair_error;
  endproperty
  a_inv: assert property (p_inv) else $error("inverse pair mismatch not flagged");
  property p_hom;
    (st && strip_cfg == `ECIC_CFG_HOMOG && (p1[0] != p1[1] || p2[0] != p2[1]))[*4] |-> pair_error;
  endproperty
  a_hom: assert property (p_hom) else $error("homogenous pair mismatch not flagged");
  property p_latch;
    pair_error && $stable(op_mode) && $stable(strip_cfg) && $stable(mixed_inverse) |=> pair_error;
  endproperty
  a_latch: assert property (p_latch) else $error("pair error dropped on its own");
  property p_cmd;
    pair_error && $past(pair_error) |-> control_cmd == 4'h0 && safe_state;
  endproperty
  a_cmd: assert property (p_cmd) else $error("commands live during pair error");
  property p_fwd;
    (sc && !sincos_fault)[*6] |-> sincos_splitter_output_sin == $past(sincos_input_one_sin, 4) + `ECIC_OFS_NORMAL;
  endproperty
  a_fwd: assert property (p_fwd) else $error("splitter output not input plus offset");
  property p_ofs;
    (sc && sincos_fault)[*6] |-> sincos_splitter_output_sin == $past(sincos_input_one_sin, 4) + `ECIC_OFS_FAULT;
  endproperty
  a_ofs: assert property (p_ofs) else $error("fault did not shift offset");
  property p_off;
    (!sc)[*6] |-> sincos_splitter_output_sin == `ECIC_OFS_FAULT;
  endproperty
  a_off: assert property (p_off) else $error("splitter forwards outside sine-cosine");
  // main scenarios
  c_step: cover property (sensor1_step);
  c_err: cover property (pair_error);
  c_flt: cover property (sc && sincos_fault);
endmodule // ecic_monitor

/* sim/ecic_source.sv */
/* ecic_source: encoders, control source and sine-cosine encoder.
   assumes the bench calls its tasks; pins change after a falling edge. */
`timescale 1ns/10ps
module ecic_source
(
  // clock
  input  wire        clk,
  // pins towards the checker
  output reg  [3:0]  strip,
  output reg  [5:0]  dif,
  output reg  [11:0] sn,
  output reg  [11:0] cs,
  output reg         flt
);
  // idle: direction pins sit low as through the pull-down
  initial
  begin
    strip = 4'h0;
    dif = 6'h00;
    sn = 12'h000;
    cs = 12'h000;
    flt = 1'b0;
  end
  // strip and encoder pins; pairs get the level the bench commands
  task drv(input [3:0] p, input [5:0] d);
    @(negedge clk);
    strip = p;
    dif = d;
  endtask
  // sine-cosine sample and monitor fault
  task smp(input [11:0] s, input [11:0] c, input f);
    @(negedge clk);
    sn = s;
    cs = c;
    flt = f;
  endtask
endmodule // ecic_source

/* sim/tb.sv */
/* tb: scenario tasks for the input checker.
   assumes ecic_source as far side and ecic_monitor bound below. */
`timescale 1ns/10ps
`include "ecic_consts.vh"
module tb;
  reg        clk = 1'b0;
  reg        sys_rst = 1'b1;
  reg  [3:0] op_mode = 4'h3;
  reg  [2:0] strip_cfg = 3'h0;
  reg        mixed_inverse = 1'b1;
  wire [3:0] strip, cmd;
  wire [5:0] dif;
  wire [11:0] sn, cs, os, oc;
  wire       flt, st1, d1, st2, d2, err, safe;
  int        errors = 0, checks = 0, n1 = 0, n2 = 0;
  always #25 clk = ~clk;
  ecic_source src_i (.clk(clk), .strip(strip), .dif(dif), .sn(sn), .cs(cs), .flt(flt));
  ecic_checker ecic_checker_i (.clk(clk), .sys_rst(sys_rst), .op_mode(op_mode), .strip_cfg(strip_cfg),
    .mixed_inverse(mixed_inverse), .diff1_a(dif[0]), .diff1_b(dif[1]), .diff1_z(dif[2]), .diff2_a(dif[3]),
    .diff2_b(dif[4]), .diff2_z(dif[5]), .control_input_strip(strip), .sincos_input_one_sin(sn),
    .sincos_input_one_cos(cs), .sincos_fault(flt), .sensor1_step(st1), .sensor1_dir(d1), .sensor2_step(st2),
    .sensor2_dir(d2), .control_cmd(cmd), .pair_error(err), .safe_state(safe),
    .sincos_splitter_output_sin(os), .sincos_splitter_output_cos(oc));
  // count step pulses
  always @(posedge clk)
  begin
    if (st1 === 1'b1) n1 = n1 + 1;
    if (st2 === 1'b1) n2 = n2 + 1;
  end
  task chk(input string n, input logic [11:0] s, input logic [11:0] e);
    checks = checks + 1;
    if (s !== e) errors = errors + 1;
    if (s !== e) $display("mismatch %s expected %h seen %h", n, e, s);
  endtask
  // wait n edges, then let that edge's updates settle before looking
  task wt(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task cfg(input [3:0] m, input [2:0] c, input [3:0] p);
    src_i.drv(p, 6'h00); wt(5);
    @(negedge clk); op_mode = m; strip_cfg = c; wt(5);
  endtask
  task t_quad;
    cfg(4'h3, `ECIC_CFG_QUAD, 4'h0); n1 = 0; n2 = 0;
    src_i.drv(4'h1, 6'h00); wt(6);
    chk("s1 steps", n1[11:0], 1); chk("s1 dir", d1, 1);
    src_i.drv(4'h5, 6'h00); wt(6);
    chk("s2 steps", n2[11:0], 1); chk("s2 dir", d2, 1);
    $display("done quadrature");
  endtask
  task t_single;
    cfg(4'h3, `ECIC_CFG_SINGLE_CH, 4'h0); n1 = 0; n2 = 0;
    src_i.drv(4'h1, 6'h00); wt(6); src_i.drv(4'h0, 6'h00); wt(6);
    chk("s1 counted", n1[11:0], 1); chk("s1 dir low", d1, 0);
    src_i.drv(4'hE, 6'h00); wt(6);
    chk("s2 counted", n2[11:0], 1); chk("s2 dir high", d2, 1);
    chk("s1 dir high", d1, 1);
    $display("done single channel");
  endtask
  task t_pairs;
    cfg(4'h3, `ECIC_CFG_INVERSE, 4'h6);
    chk("inv ok", err, 0); chk("inv cmd", cmd, 4'h2);
    src_i.drv(4'h7, 6'h00); wt(6);
    chk("inv err", err, 1); chk("inv off", cmd, 0); chk("inv safe", safe, 1);
    src_i.drv(4'h6, 6'h00); wt(6); chk("err held", err, 1);
    @(negedge clk); strip_cfg = `ECIC_CFG_SINGLES; wt(4);
    chk("reconf clr", err, 0); chk("singles", cmd, 4'h6);
    cfg(4'h3, `ECIC_CFG_HOMOG, 4'hF); chk("hom cmd", cmd, 4'h3);
    src_i.drv(4'hB, 6'h00); wt(6); chk("hom err", err, 1);
    @(negedge clk); sys_rst = 1'b1; wt(2); @(negedge clk); sys_rst = 1'b0; @(negedge clk);
    chk("rst clr", err, 0); wt(6); chk("redetect", err, 1);
    cfg(4'h3, `ECIC_CFG_MIXED, 4'hE); chk("mix cmd", cmd, 4'h6);
    @(negedge clk); mixed_inverse = 1'b0; wt(6); chk("mix err", err, 1);
    $display("done pairs");
  endtask
  task t_diff;
    cfg(4'h7, `ECIC_CFG_QUAD, 4'h0); n1 = 0;
    src_i.drv(4'h0, 6'h04); wt(6); chk("index off", n1[11:0], 0);
    src_i.drv(4'h0, 6'h05); wt(6); chk("diff step", n1[11:0], 1);
    chk("diff fwd", d1, 1);
    src_i.drv(4'h0, 6'h04); wt(6); chk("diff back", n1[11:0], 2);
    chk("diff rev", d1, 0);
    cfg(4'h3, `ECIC_CFG_QUAD, 4'h0); n1 = 0;
    src_i.drv(4'h0, 6'h01); wt(6); chk("diff ignored", n1[11:0], 0);
    $display("done differential");
  endtask
  task t_sc;
    @(negedge clk); op_mode = 4'h0;
    src_i.smp(12'h123, 12'hF00, 1'b0); wt(8);
    chk("sin fwd", os, 12'h923); chk("cos fwd", oc, 12'h700);
    src_i.smp(12'h123, 12'hF00, 1'b1); wt(8);
    chk("sin fault", os, 12'h323); chk("fault safe", safe, 1);
    src_i.smp(12'h123, 12'hF00, 1'b0); wt(4);
    @(negedge clk); op_mode = 4'h3; wt(8); chk("not fwd", os, 12'h200);
    $display("done splitter");
  endtask
  task close_out;
    $display("checks %0d mismatches %0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // main sequence
  initial
  begin
    wt(8);
    @(negedge clk); sys_rst = 1'b0;
    t_quad; t_single; t_pairs; t_diff; t_sc;
    close_out;
  end
  // watchdog
  initial
  begin
    #200000;
    errors = errors + 1;
    close_out;
  end
endmodule // tb
bind ecic_checker ecic_monitor ecic_monitor_i (.clk(clk), .sys_rst(sys_rst), .op_mode(op_mode),
  .strip_cfg(strip_cfg), .mixed_inverse(mixed_inverse), .control_input_strip(control_input_strip),
  .sincos_input_one_sin(sincos_input_one_sin), .sincos_fault(sincos_fault), .sensor1_step(sensor1_step),
  .control_cmd(control_cmd), .pair_error(pair_error), .safe_state(safe_state),
  .sincos_splitter_output_sin(sincos_splitter_output_sin));
